// file: rtl/req_sync.sv
// Purpose: two-flop synchronisers for the asynchronous request pins
// Assumes: pins may change at any time relative to clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module req_sync
    import sideband_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // raw pins
    input wire logic mgmtInterruptReqN,
    input wire logic clockHaltReqN,
    input wire logic sleepReqN,
    // synchronised levels
    req_sync_if.src sy
);

    // =====================================================================
    // synchroniser stages
    // =====================================================================
    logic [2:0] stage1;
    logic [2:0] stage2;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {3{SYNC_RESET}};
            stage2 <= {3{SYNC_RESET}};
        end else begin
            stage1 <= {mgmtInterruptReqN, clockHaltReqN, sleepReqN}; // see RULE12
            stage2 <= stage1; // see RULE15
        end
    end

    assign sy.mgmtReqN = stage2[2];
    assign sy.haltReqN = stage2[1];
    assign sy.sleepReqN = stage2[0];

    // =====================================================================
    // checks
    // =====================================================================
    property p_sync_two_stage;
        @(posedge clock) disable iff (!rst_n)
        (rst_n && $past(rst_n, 2)) |-> (stage2 == $past({mgmtInterruptReqN,
            clockHaltReqN, sleepReqN}, 2));
    endproperty
    a_sync_two_stage: assert property (p_sync_two_stage) // see RULE15
        else $error("request synchroniser is not two stages deep");

endmodule : req_sync

// file: rtl/req_sync_if.sv
// Purpose: carries synchronised request levels between modules
// Assumes: all signals on the processor clock
// Notes: levels stay active low
`timescale 1ns/1ps
interface req_sync_if;
    logic mgmtReqN;
    logic haltReqN;
    logic sleepReqN;

    modport src (output mgmtReqN, output haltReqN, output sleepReqN);
    modport dst (input mgmtReqN, input haltReqN, input sleepReqN);
endinterface : req_sync_if

// file: rtl/sideband_ctrl.sv
// Purpose: management interrupt and clock-halt sideband control of the core
// Assumes: chipset drives the request pins asynchronously; bus interface
//          accepts acknowledge transactions with busAckReady
// Notes: clock enables steer the core clock gates; pinsDriveEn feeds pads
//
// Function
// RULE1 - management request may arrive anytime; accepted as asynchronous input
// RULE2 - accepted management request saves state and enters protected handler mode
// RULE3 - entering handler mode issues a management acknowledge on the bus
// RULE4 - after entry the core fetches from the handler, not the program
// RULE5 - management request active at reset release floats all outputs
// RULE6 - asserted halt request moves the core into clock-halt state
// RULE7 - entering clock-halt issues a halt acknowledge on the bus
// RULE8 - in clock-halt only bus interface and interrupt controller keep clocks
// RULE9 - in clock-halt snoops and interrupt service continue
// RULE10 - removed halt request re-enables all clocks and resumes execution
// RULE11 - halt request never touches bus clock; only core clocks gate
// RULE12 - halt request is an asynchronous input
// RULE13 - sleep request in clock-halt stops all clocks but the clock loop
// RULE14 - removed sleep request returns to clock-halt, bus clock restarts
// RULE15 - each request passes a two-flop synchroniser first
// RULE16 - halt acknowledge goes out before core clocks are gated
`timescale 1ns/1ps
module sideband_ctrl
    import sideband_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // request pins from chipset
    input wire logic mgmtInterruptReqN,
    input wire logic clockHaltReqN,
    input wire logic sleepReqN,
    // core and bus interface handshakes
    input wire logic busAckReady,
    input wire logic handlerReturn,
    // acknowledge transaction to the bus
    output logic busAckValid,
    output logic busAckKind,
    // core control
    output logic saveState,
    output logic handlerFetch,
    output logic handlerMode,
    output logic resumeExec,
    // clock gates and service enables
    output logic coreClkEn,
    output logic busClkEn,
    output logic intCtrlClkEn,
    output logic snoopEn,
    output logic intServiceEn,
    // pad drive
    output logic pinsDriveEn
);

    // =====================================================================
    // synchronisers
    // =====================================================================
    req_sync_if sy ();

    req_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .mgmtInterruptReqN(mgmtInterruptReqN),
        .clockHaltReqN(clockHaltReqN),
        .sleepReqN(sleepReqN),
        .sy(sy)
    );

    logic haltActive;
    logic sleepActive;
    assign haltActive = ~sy.haltReqN;
    assign sleepActive = ~sy.sleepReqN;

    // =====================================================================
    // startup and output float strap
    // =====================================================================
    logic [1:0] startCnt;
    logic startDone;

    // strap judged only once the synchroniser holds the level seen at release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            startCnt <= STARTUP_RESET;
            startDone <= OFF;
            pinsDriveEn <= OFF;
        end else if (!startDone) begin
            startCnt <= startCnt + 2'h1;
            if (startCnt == STARTUP_CYCLES - 2'h1) begin
                startDone <= ON;
                pinsDriveEn <= sy.mgmtReqN; // see RULE5
            end
        end
    end

    // =====================================================================
    // management request capture
    // =====================================================================
    logic mgmtPrev;
    logic mgmtPending;
    logic mgmtTaken;
    ctl_state_e state;
    ctl_state_e next_state;

    assign mgmtTaken = (state == ST_RUN) && (next_state == ST_SAVE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mgmtPrev <= REQ_INACTIVE;
        end else begin
            mgmtPrev <= sy.mgmtReqN;
        end
    end

    // an edge in the same cycle as the take wins over the clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mgmtPending <= OFF;
        end else if (startDone && mgmtPrev && !sy.mgmtReqN) begin
            mgmtPending <= ON; // see RULE1
        end else if (mgmtTaken) begin
            mgmtPending <= OFF;
        end
    end

    // =====================================================================
    // control state machine
    // =====================================================================
    // halt wins over a pending management request; no nesting in the handler
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (startDone && haltActive) begin
                    next_state = ST_HALT_ACK; // see RULE6
                end else if (startDone && mgmtPending && !handlerMode) begin
                    next_state = ST_SAVE; // see RULE2
                end
            end
            ST_SAVE: begin
                next_state = ST_MGMT_ACK; // see RULE3
            end
            ST_MGMT_ACK: begin
                if (busAckReady) begin
                    next_state = ST_RUN; // see RULE4
                end
            end
            ST_HALT_ACK: begin
                if (busAckReady) begin
                    next_state = ST_HALTED; // see RULE16
                end
            end
            ST_HALTED: begin
                if (sleepActive) begin
                    next_state = ST_SLEEP; // see RULE13
                end else if (!haltActive) begin
                    next_state = ST_RUN; // see RULE10
                end
            end
            ST_SLEEP: begin
                if (!sleepActive) begin
                    next_state = ST_HALTED; // see RULE14
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // bus acknowledge and core control
    // =====================================================================
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busAckValid <= OFF;
            busAckKind <= ACK_KIND_MGMT;
        end else begin
            busAckValid <= (next_state == ST_MGMT_ACK) || (next_state == ST_HALT_ACK); // see RULE7
            busAckKind <= (next_state == ST_HALT_ACK) ? ACK_KIND_HALT : ACK_KIND_MGMT;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            saveState <= OFF;
            handlerFetch <= OFF;
            resumeExec <= OFF;
        end else begin
            saveState <= mgmtTaken; // see RULE2
            handlerFetch <= (state == ST_MGMT_ACK) && (next_state == ST_RUN); // see RULE4
            resumeExec <= (state == ST_HALTED) && (next_state == ST_RUN); // see RULE10
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            handlerMode <= OFF;
        end else if ((state == ST_MGMT_ACK) && busAckReady) begin
            handlerMode <= ON; // see RULE2
        end else if ((state == ST_RUN) && handlerReturn) begin
            handlerMode <= OFF;
        end
    end

    // =====================================================================
    // clock gates
    // =====================================================================
    // core stays clocked through the halt acknowledge so it reaches the bus
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            coreClkEn <= ON;
            busClkEn <= ON;
            intCtrlClkEn <= ON;
            snoopEn <= ON;
            intServiceEn <= ON;
        end else begin
            coreClkEn <= (next_state != ST_HALTED) && (next_state != ST_SLEEP); // see RULE8
            busClkEn <= (next_state != ST_SLEEP); // see RULE11
            intCtrlClkEn <= (next_state != ST_SLEEP); // see RULE8
            snoopEn <= (next_state != ST_SLEEP); // see RULE9
            intServiceEn <= (next_state != ST_SLEEP); // see RULE9
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    property p_mgmt_capture;
        @(posedge clock) disable iff (!rst_n)
        (startDone && mgmtPrev && !sy.mgmtReqN) |=> mgmtPending;
    endproperty
    a_mgmt_capture: assert property (p_mgmt_capture) // see RULE1
        else $error("management request edge was lost");

    property p_save_then_ack;
        @(posedge clock) disable iff (!rst_n)
        saveState |=> (busAckValid && (busAckKind == ACK_KIND_MGMT));
    endproperty
    a_save_then_ack: assert property (p_save_then_ack) // see RULE3
        else $error("no management acknowledge after state save");

    property p_handler_entry;
        @(posedge clock) disable iff (!rst_n)
        (busAckValid && (busAckKind == ACK_KIND_MGMT) && busAckReady)
            |=> (handlerFetch && handlerMode) ##1 !handlerFetch;
    endproperty
    a_handler_entry: assert property (p_handler_entry) // see RULE4
        else $error("handler fetch not started after acknowledge");

    property p_float_strap;
        @(posedge clock) disable iff (!rst_n)
        $rose(startDone) |-> (pinsDriveEn == $past(sy.mgmtReqN));
    endproperty
    a_float_strap: assert property (p_float_strap) // see RULE5
        else $error("output float strap not taken at release");

    property p_float_hold;
        @(posedge clock) disable iff (!rst_n)
        (startDone && !pinsDriveEn) |=> !pinsDriveEn;
    endproperty
    a_float_hold: assert property (p_float_hold) // see RULE5
        else $error("outputs left float mode before reset");

    property p_halt_entry;
        @(posedge clock) disable iff (!rst_n)
        (startDone && (state == ST_RUN) && haltActive)
            |=> (busAckValid && (busAckKind == ACK_KIND_HALT) && coreClkEn);
    endproperty
    a_halt_entry: assert property (p_halt_entry) // see RULE7
        else $error("halt request did not start halt acknowledge");

    property p_ack_before_gate;
        @(posedge clock) disable iff (!rst_n)
        $fell(coreClkEn) |-> $past(busAckValid && busAckKind && busAckReady);
    endproperty
    a_ack_before_gate: assert property (p_ack_before_gate) // see RULE16
        else $error("core clocks gated before halt acknowledge");

    property p_halted_units;
        @(posedge clock) disable iff (!rst_n)
        (state == ST_HALTED) |-> (!coreClkEn && busClkEn && intCtrlClkEn
            && snoopEn && intServiceEn);
    endproperty
    a_halted_units: assert property (p_halted_units) // see RULE8 RULE9 RULE11
        else $error("wrong clock gating in clock-halt state");

    property p_resume;
        @(posedge clock) disable iff (!rst_n)
        ((state == ST_HALTED) && !haltActive && !sleepActive)
            |=> (coreClkEn && resumeExec && (state == ST_RUN));
    endproperty
    a_resume: assert property (p_resume) // see RULE10
        else $error("no resume after halt request removed");

    property p_sleep;
        @(posedge clock) disable iff (!rst_n)
        ((state == ST_HALTED) && sleepActive)
            |=> (!coreClkEn && !busClkEn && !intCtrlClkEn && !snoopEn);
    endproperty
    a_sleep: assert property (p_sleep) // see RULE13
        else $error("sleep did not stop all clocks");

    property p_wake;
        @(posedge clock) disable iff (!rst_n)
        ((state == ST_SLEEP) && !sleepActive)
            |=> (busClkEn && !coreClkEn && (state == ST_HALTED));
    endproperty
    a_wake: assert property (p_wake) // see RULE14
        else $error("sleep exit did not return to clock-halt");

endmodule : sideband_ctrl

// file: rtl/sideband_pkg.sv
// Purpose: shared constants and types for the sideband request control
// Assumes: one processor clock domain, asynchronous active-low reset
// Notes: request pins are active low
package sideband_pkg;

    // =====================================================================
    // request levels and reset values
    // =====================================================================
    localparam logic REQ_INACTIVE = 1'h1;
    localparam logic SYNC_RESET = 1'h1;
    localparam logic OFF = 1'h0;
    localparam logic ON = 1'h1;

    // =====================================================================
    // acknowledge transaction kinds
    // =====================================================================
    localparam logic ACK_KIND_MGMT = 1'h0;
    localparam logic ACK_KIND_HALT = 1'h1;

    // =====================================================================
    // startup: edges after reset release before the strap is judged
    // =====================================================================
    localparam logic [1:0] STARTUP_CYCLES = 2'h3;
    localparam logic [1:0] STARTUP_RESET = 2'h0;

    // =====================================================================
    // control states
    // =====================================================================
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SAVE,
        ST_MGMT_ACK,
        ST_HALT_ACK,
        ST_HALTED,
        ST_SLEEP
    } ctl_state_e;

endpackage : sideband_pkg

// file: testbench/chipset_model.sv
// Purpose: chipset side that drives the sideband request pins
// Assumes: the bench asks for request levels, active high; pins are active low
// Notes: slow mode moves pin changes well away from the clock edge
`timescale 1ns/1ps
module chipset_model (
    // clock
    input wire logic clock,
    // levels wanted by the bench
    input wire logic wantMgmt,
    input wire logic wantHalt,
    input wire logic wantSleep,
    input wire logic slow,
    // request pins to the device
    output logic mgmtInterruptReqN,
    output logic clockHaltReqN,
    output logic sleepReqN
);
    // =====================================================================
    // pin drive
    // =====================================================================
    // one process owns the pins, so each has a single driver
    // mid-cycle changes: the device must not rely on edge alignment
    initial begin
        mgmtInterruptReqN = 1'h1;
        clockHaltReqN = 1'h1;
        sleepReqN = 1'h1;
        forever begin
            @(posedge clock);
            if (slow) begin
                #17;
            end
            mgmtInterruptReqN <= ~wantMgmt;
            clockHaltReqN <= ~wantHalt;
            sleepReqN <= ~wantSleep;
        end
    end
endmodule : chipset_model

// file: testbench/testbench.sv
// Purpose: self-checking bench for the sideband request control
// Assumes: 25 MHz clock; bench plays bus interface and core handshakes
// Notes: a queue of expected acknowledge kinds is compared at every accept
`timescale 1ns/1ps
module testbench
    import sideband_pkg::*;
;
    // =====================================================================
    // signals
    // =====================================================================
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic wantMgmt = 1'h0;
    logic wantHalt = 1'h0;
    logic wantSleep = 1'h0;
    logic slow = 1'h0;
    logic busAckReady = 1'h0;
    logic handlerReturn = 1'h0;
    wire logic mgmtInterruptReqN, clockHaltReqN, sleepReqN;
    logic busAckValid, busAckKind, saveState, handlerFetch, handlerMode;
    logic resumeExec, coreClkEn, busClkEn, intCtrlClkEn, snoopEn;
    logic intServiceEn, pinsDriveEn;
    integer err_count = 0;
    integer total_checks = 0;
    integer seed = 32'he69f;
    logic expKind[$];

    initial begin
        forever #20 clock = ~clock;
    end

    chipset_model u_chipset_model (.clock(clock), .wantMgmt(wantMgmt),
        .wantHalt(wantHalt), .wantSleep(wantSleep), .slow(slow),
        .mgmtInterruptReqN(mgmtInterruptReqN), .clockHaltReqN(clockHaltReqN),
        .sleepReqN(sleepReqN));

    sideband_ctrl u_sideband_ctrl (.clock(clock), .rst_n(rst_n),
        .mgmtInterruptReqN(mgmtInterruptReqN), .clockHaltReqN(clockHaltReqN),
        .sleepReqN(sleepReqN), .busAckReady(busAckReady),
        .handlerReturn(handlerReturn), .busAckValid(busAckValid),
        .busAckKind(busAckKind), .saveState(saveState),
        .handlerFetch(handlerFetch), .handlerMode(handlerMode),
        .resumeExec(resumeExec), .coreClkEn(coreClkEn), .busClkEn(busClkEn),
        .intCtrlClkEn(intCtrlClkEn), .snoopEn(snoopEn),
        .intServiceEn(intServiceEn), .pinsDriveEn(pinsDriveEn));

    // =====================================================================
    // helpers
    // =====================================================================
    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    // waits at falling edges, where outputs have settled
    task automatic wait_sig(input int which, input logic lvl);
        logic v;
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            case (which)
                0: v = saveState;
                1: v = busAckValid;
                2: v = busClkEn;
                default: v = resumeExec;
            endcase
            if (v === lvl) begin
                return;
            end
        end
        err_count++;
        $display("ERROR wait %0d expected %b seen timeout", which, lvl);
        final_report();
    endtask : wait_sig

    task automatic reset_run(input logic mgmtLow);
        @(posedge clock);
        rst_n <= 1'h0;
        wantMgmt <= mgmtLow;
        repeat (8) @(posedge clock);
        check("floatInReset", pinsDriveEn, OFF);
        check("ackInReset", busAckValid, OFF);
        check("coreInReset", coreClkEn, ON);
        rst_n <= 1'h1;
        repeat (20) begin
            @(negedge clock);
            check("noEdgeNoSave", saveState, OFF);
        end
        check("pinsDrive", pinsDriveEn, ~mgmtLow);
        @(posedge clock);
        wantMgmt <= 1'h0;
    endtask : reset_run

    task automatic take_ack(input int stall);
        logic kind;
        // expected kind comes from the model queue, never from the design
        kind = expKind.pop_front();
        wait_sig(1, ON);
        repeat (stall) begin
            @(negedge clock);
            check("ackStands", busAckValid, ON);
        end
        @(posedge clock);
        busAckReady <= 1'h1;
        @(negedge clock);
        check("ackKind", busAckKind, kind);
        if (kind == ACK_KIND_HALT) begin
            check("haltAckFirst", coreClkEn, ON);
        end
        @(posedge clock);
        busAckReady <= 1'h0;
        @(negedge clock);
        check("ackDone", busAckValid, OFF);
    endtask : take_ack

    task automatic mgmt_pulse;
        @(posedge clock);
        wantMgmt <= 1'h1;
        repeat (2) @(posedge clock);
        wantMgmt <= 1'h0;
        expKind.push_back(ACK_KIND_MGMT);
    endtask : mgmt_pulse

    task automatic mgmt_flow(input int stall, input logic saveSeen);
        if (!saveSeen) begin
            wait_sig(0, ON);
        end
        @(negedge clock);
        check("saveThenAck", busAckValid, ON);
        check("savePulse", saveState, OFF);
        take_ack(stall);
        check("handlerMode", handlerMode, ON);
        check("handlerFetch", handlerFetch, ON);
        @(negedge clock);
        check("fetchPulse", handlerFetch, OFF);
        @(posedge clock);
        handlerReturn <= 1'h1;
        @(posedge clock);
        handlerReturn <= 1'h0;
        @(negedge clock);
        check("handlerLeft", handlerMode, OFF);
    endtask : mgmt_flow

    // =====================================================================
    // scenarios
    // =====================================================================
    initial begin
        reset_run(1'h1);
        $display("test float strap done");
        reset_run(1'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            slow <= 1'($random(seed));
            mgmt_pulse();
            mgmt_flow($unsigned($random(seed)) % 4, 1'h0);
        end
        $display("test management requests done");
        @(posedge clock);
        slow <= 1'h1;
        wantHalt <= 1'h1;
        expKind.push_back(ACK_KIND_HALT);
        take_ack(2);
        check("coreGated", coreClkEn, OFF);
        check("busClkKept", busClkEn, ON);
        check("intClkKept", intCtrlClkEn, ON);
        check("snoopKept", snoopEn, ON);
        check("intSrvKept", intServiceEn, ON);
        mgmt_pulse();
        repeat (8) begin
            @(negedge clock);
            check("mgmtHeldOff", saveState, OFF);
        end
        @(posedge clock);
        wantSleep <= 1'h1;
        wait_sig(2, OFF);
        check("sleepInt", intCtrlClkEn, OFF);
        check("sleepSnoop", snoopEn, OFF);
        check("sleepSrv", intServiceEn, OFF);
        check("sleepCore", coreClkEn, OFF);
        @(posedge clock);
        wantSleep <= 1'h0;
        wait_sig(2, ON);
        check("wakeSnoop", snoopEn, ON);
        check("wakeCore", coreClkEn, OFF);
        @(posedge clock);
        wantHalt <= 1'h0;
        wait_sig(3, ON);
        check("coreRuns", coreClkEn, ON);
        // held request is taken one edge after resume; its save pulse is here
        @(negedge clock);
        check("resumePulse", resumeExec, OFF);
        check("heldMgmtSaved", saveState, ON);
        mgmt_flow(0, 1'h1);
        check("queueEmpty", expKind.size() == 0, 1'h1);
        $display("test clock halt done");
        final_report();
    end
endmodule : testbench
